// ---- verilog/lictl_defs.vh ----
/*
 * Constants of the line interface control register bank: offsets, field positions,
 * reset values and the interrupt register block.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef LICTL_DEFS_VH
`define LICTL_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LICTL_ADDR_W          4
`define LICTL_OFF_CTRL1       4'h5
`define LICTL_OFF_CTRL2       4'h6
`define LICTL_OFF_RSVD7       4'h7
`define LICTL_OFF_RSVD8       4'h8
`define LICTL_OFF_SRATE       4'h9
`define LICTL_OFF_RSVD10      4'ha
`define LICTL_OFF_REV         4'hb
`define LICTL_OFF_STAT        4'hc
`define LICTL_OFF_IRQ_STAT    4'hd
`define LICTL_OFF_IRQ_EN      4'he
`define LICTL_OFF_IRQ_CLR     4'hf

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LICTL_CTRL2_RST       8'h70
`define LICTL_TXL_RST         2'b10
`define LICTL_RXL_RST         2'b10
`define LICTL_MUTE_RST        1'b1
`define LICTL_PDL_RST         1'b1
`define LICTL_CTRL2_MASK      8'h7b
`define LICTL_SRATE_RST       8'h00
`define LICTL_SRATE_MASK      8'h07
`define LICTL_BIT_TXL_HI      6
`define LICTL_BIT_RXL_HI      5
`define LICTL_BIT_PDL         4
`define LICTL_BIT_PDN         3
`define LICTL_BIT_TXL_LO      1
`define LICTL_BIT_RXL_LO      0
`define LICTL_BIT_OFFHOOK     0
`define LICTL_BIT_LINKERR     7
`define LICTL_BIT_FRAME       6
`define LICTL_LVL_MUTE        2'b10
`define LICTL_SRATE_RSVD      3'b111
`define LICTL_SENSE_HI_EXC    5'h1e
`define LICTL_SENSE_LO_EXC    5'h01
`define LICTL_LCS_HI_EXC      4'he
`define LICTL_LCS_LO_EXC      4'h1
`define LICTL_REV_DEFAULT     4'h1

// Interrupt status bits: link error, frame lock lost, frame lock gained
`define LICTL_IRQ_W           3
`define LICTL_IRQ_LINKERR     0
`define LICTL_IRQ_LOCKLOSS    1
`define LICTL_IRQ_LOCKGAIN    2

`endif

// ---- verilog/lictl_sync.v ----
/*
 * Two-flip-flop synchroniser for a bus of levels.
 * Assumes inputs are quasi-static levels from outside the clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module lictl_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         resetn,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_r;

    // First stage feeds only the second stage
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // lictl_sync
`default_nettype wire

// ---- verilog/lictl_lcs_decode.v ----
/*
 * Loop current decode from the five-bit line sense value.
 * Assumes a synchronised sense value and hook state from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lictl_defs.vh"
module lictl_lcs_decode (
    input  wire [4:0] line_sense_raw,
    input  wire       off_hook,
    output reg  [3:0] loop_current_sense
);
    // Off-hook applies the two end exceptions, on-hook takes bits 4:1
    always @* begin
        loop_current_sense = line_sense_raw[4:1];
        if (off_hook) begin
            if (line_sense_raw == `LICTL_SENSE_HI_EXC)
                loop_current_sense = `LICTL_LCS_HI_EXC;
            else if (line_sense_raw == `LICTL_SENSE_LO_EXC)
                loop_current_sense = `LICTL_LCS_LO_EXC;
        end
    end
endmodule // lictl_lcs_decode
`default_nettype wire

// ---- verilog/lictl_regs.v ----
/*
 * Line interface control register bank: call-progress levels, power-down,
 * sample rate, revision readout, line-side status and a small interrupt block.
 * Assumes a host port with one-cycle strobes, read data in the following cycle,
 * and line-side status pins asynchronous to clk.
 */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "lictl_defs.vh"
module lictl_regs #(
    parameter [3:0] REV_VALUE = `LICTL_REV_DEFAULT   // Arbitrary revision value
) (
    input  wire       clk,
    input  wire       resetn,
    input  wire [3:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr_en,
    input  wire       rd_en,
    output reg  [7:0] rdata,
    input  wire       link_error_pin,
    input  wire       frame_lock_pin,
    input  wire [4:0] line_sense_pin,
    output reg  [1:0] callprog_tx_level,
    output reg  [1:0] callprog_rx_level,
    output reg        callprog_tx_mute,
    output reg        callprog_rx_mute,
    output reg        line_side_powerdown,
    output reg        system_side_powerdown,
    output reg  [2:0] sample_rate_select,
    output reg        sample_rate_invalid,
    output reg        off_hook_request,
    output wire       irq
);
    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    reg  [7:0] ctrl1_r;
    reg  [7:0] ctrl2_r;
    reg  [7:0] srate_r;
    reg        linkerr_r;
    reg        frame_d_r;
    reg  [`LICTL_IRQ_W-1:0] irq_stat_r;
    reg  [`LICTL_IRQ_W-1:0] irq_en_r;
    reg  [`LICTL_IRQ_W-1:0] irq_set;
    reg  [`LICTL_IRQ_W-1:0] irq_stat_nxt;
    reg  [7:0] rdata_nxt;
    wire [6:0] sync_q;
    wire       linkerr_s;
    wire       frame_s;
    wire [4:0] sense_s;
    wire [3:0] lcs;
    wire       wr_ctrl1;
    wire       wr_ctrl2;
    wire       wr_srate;
    wire       wr_stat;

    // ------------------------------------------------------------------------
    // Input synchronisation and decode
    // ------------------------------------------------------------------------
    lictl_sync #(
        .W (7)
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      ({link_error_pin, frame_lock_pin, line_sense_pin}),
        .q      (sync_q)
    );
    assign linkerr_s = sync_q[6];
    assign frame_s   = sync_q[5];
    assign sense_s   = sync_q[4:0];

    lictl_lcs_decode u_lcs (
        .line_sense_raw     (sense_s),
        .off_hook           (ctrl1_r[`LICTL_BIT_OFFHOOK]),
        .loop_current_sense (lcs)
    );

    // Write strobes per register; reserved and read-only offsets get none
    assign wr_ctrl1 = wr_en && (addr == `LICTL_OFF_CTRL1);
    assign wr_ctrl2 = wr_en && (addr == `LICTL_OFF_CTRL2);
    assign wr_srate = wr_en && (addr == `LICTL_OFF_SRATE);
    assign wr_stat  = wr_en && (addr == `LICTL_OFF_STAT);

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    // Writable bits only; reserved bits stay zero
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl1_r <= 8'h00;
            ctrl2_r <= `LICTL_CTRL2_RST;
            srate_r <= `LICTL_SRATE_RST;
        end else begin
            if (wr_ctrl1)
                ctrl1_r <= wdata & 8'h01;
            if (wr_ctrl2)
                ctrl2_r <= wdata & `LICTL_CTRL2_MASK;
            if (wr_srate)
                srate_r <= wdata & `LICTL_SRATE_MASK;
        end
    end

    // System-side power-down latches; only reset restores operation
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            system_side_powerdown <= 1'b0;
        else if (wr_ctrl2 && wdata[`LICTL_BIT_PDN])
            system_side_powerdown <= 1'b1;
    end

    // Control outputs from registers; reset values match the control register
    // reset so the line side never leaves power-down for a cycle after reset
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            callprog_tx_level   <= `LICTL_TXL_RST;
            callprog_rx_level   <= `LICTL_RXL_RST;
            callprog_tx_mute    <= `LICTL_MUTE_RST;
            callprog_rx_mute    <= `LICTL_MUTE_RST;
            line_side_powerdown <= `LICTL_PDL_RST;
            sample_rate_select  <= 3'b000;
            sample_rate_invalid <= 1'b0;
            off_hook_request    <= 1'b0;
        end else begin
            callprog_tx_level   <= {ctrl2_r[`LICTL_BIT_TXL_HI], ctrl2_r[`LICTL_BIT_TXL_LO]};
            callprog_rx_level   <= {ctrl2_r[`LICTL_BIT_RXL_HI], ctrl2_r[`LICTL_BIT_RXL_LO]};
            callprog_tx_mute    <= ({ctrl2_r[`LICTL_BIT_TXL_HI], ctrl2_r[`LICTL_BIT_TXL_LO]}
                                    == `LICTL_LVL_MUTE);
            callprog_rx_mute    <= ({ctrl2_r[`LICTL_BIT_RXL_HI], ctrl2_r[`LICTL_BIT_RXL_LO]}
                                    == `LICTL_LVL_MUTE);
            line_side_powerdown <= ctrl2_r[`LICTL_BIT_PDL];
            sample_rate_select  <= srate_r[2:0];
            sample_rate_invalid <= (srate_r[2:0] == `LICTL_SRATE_RSVD);
            off_hook_request    <= ctrl1_r[`LICTL_BIT_OFFHOOK];
        end
    end

    // ------------------------------------------------------------------------
    // Link status
    // ------------------------------------------------------------------------
    // Sticky link error; set wins over a zero write in the same cycle
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            linkerr_r <= 1'b0;
        else if (linkerr_s)
            linkerr_r <= 1'b1;
        else if (wr_stat && !wdata[`LICTL_BIT_LINKERR])
            linkerr_r <= 1'b0;
    end

    // Delayed frame flag for edge events
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            frame_d_r <= 1'b0;
        else
            frame_d_r <= frame_s;
    end

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    // Event sources, sticky status, write-one clear with set priority
    always @* begin
        irq_set = {`LICTL_IRQ_W{1'b0}};
        irq_set[`LICTL_IRQ_LINKERR]  = linkerr_s && !linkerr_r;
        irq_set[`LICTL_IRQ_LOCKLOSS] = frame_d_r && !frame_s;
        irq_set[`LICTL_IRQ_LOCKGAIN] = !frame_d_r && frame_s;
        irq_stat_nxt = irq_stat_r;
        if (wr_en && (addr == `LICTL_OFF_IRQ_CLR))
            irq_stat_nxt = irq_stat_nxt & ~wdata[`LICTL_IRQ_W-1:0];
        irq_stat_nxt = irq_stat_nxt | irq_set;
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_r <= {`LICTL_IRQ_W{1'b0}};
            irq_en_r   <= {`LICTL_IRQ_W{1'b0}};
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (wr_en && (addr == `LICTL_OFF_IRQ_EN))
                irq_en_r <= wdata[`LICTL_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_en_r);

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    // Read mux; unmapped and reserved offsets read zero
    always @* begin
        rdata_nxt = 8'h00;
        case (addr)
            `LICTL_OFF_CTRL1:    rdata_nxt = ctrl1_r;
            `LICTL_OFF_CTRL2:    rdata_nxt = ctrl2_r | (system_side_powerdown
                                             ? 8'h08 : 8'h00);
            `LICTL_OFF_SRATE:    rdata_nxt = srate_r;
            `LICTL_OFF_REV:      rdata_nxt = {4'h0, REV_VALUE};
            `LICTL_OFF_STAT:     rdata_nxt = {linkerr_r, frame_s, 2'b00, lcs};
            `LICTL_OFF_IRQ_STAT: rdata_nxt = {5'h00, irq_stat_r};
            `LICTL_OFF_IRQ_EN:   rdata_nxt = {5'h00, irq_en_r};
            default:             rdata_nxt = 8'h00;
        endcase
    end

    // Read data registered, valid only in the cycle after the strobe
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            rdata <= 8'h00;
        else if (rd_en)
            rdata <= rdata_nxt;
        else
            rdata <= 8'h00;
    end
endmodule // lictl_regs
`default_nettype wire

// ---- testbench/lictl_regs_asserts.sv ----
/* Port checker of the register bank.
   Assumes binding to lictl_regs, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
// ----
// Checker
// ----
module lictl_regs_asserts #(
    parameter [3:0] REV_VALUE = 4'h1
) (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    input wire logic [1:0] callprog_tx_level,
    input wire logic [1:0] callprog_rx_level,
    input wire logic       callprog_tx_mute,
    input wire logic       callprog_rx_mute,
    input wire logic       line_side_powerdown,
    input wire logic       system_side_powerdown,
    input wire logic [2:0] sample_rate_select,
    input wire logic       sample_rate_invalid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Host strobes at one offset
    sequence s_wr(logic [3:0] a); wr_en && addr == a; endsequence
    sequence s_rd(logic [3:0] a); rd_en && addr == a; endsequence
    property p_txm; callprog_tx_mute == (callprog_tx_level == 2'b10); endproperty
    property p_rxm; callprog_rx_mute == (callprog_rx_level == 2'b10); endproperty
    property p_txl;
        s_wr(4'h6) |-> ##2 callprog_tx_level == {$past(wdata[6], 2), $past(wdata[1], 2)};
    endproperty
    property p_rxl;
        s_wr(4'h6) |-> ##2 callprog_rx_level == {$past(wdata[5], 2), $past(wdata[0], 2)};
    endproperty
    property p_pdl; s_wr(4'h6) |-> ##2 line_side_powerdown == $past(wdata[4], 2); endproperty
    property p_pdn; s_wr(4'h6) ##0 wdata[3] |-> ##2 system_side_powerdown; endproperty
    property p_hold; system_side_powerdown |=> system_side_powerdown; endproperty
    property p_src; s_wr(4'h9) |-> ##2 sample_rate_select == $past(wdata[2:0], 2); endproperty
    property p_inv; sample_rate_invalid == (sample_rate_select == 3'h7); endproperty
    property p_rev; s_rd(4'hb) |=> rdata == {4'h0, REV_VALUE}; endproperty
    property p_rsv; s_rd(4'h7) or s_rd(4'h8) or s_rd(4'ha) |=> rdata == 8'h00; endproperty
    a_txm: assert property (p_txm) else $error("tx mute wrong");
    a_rxm: assert property (p_rxm) else $error("rx mute wrong");
    a_txl: assert property (p_txl) else $error("tx level wrong");
    a_rxl: assert property (p_rxl) else $error("rx level wrong");
    a_pdl: assert property (p_pdl) else $error("line powerdown wrong");
    a_pdn: assert property (p_pdn) else $error("module powerdown missed");
    a_hold: assert property (p_hold) else $error("module powerdown dropped");
    a_src: assert property (p_src) else $error("sample rate wrong");
    a_inv: assert property (p_inv) else $error("invalid flag wrong");
    a_rev: assert property (p_rev) else $error("revision wrong");
    a_rsv: assert property (p_rsv) else $error("reserved not zero");
endmodule // lictl_regs_asserts
bind lictl_regs lictl_regs_asserts #(.REV_VALUE(REV_VALUE)) i_lictl_regs_asserts (.clk, .resetn,
    .addr, .wdata, .wr_en, .rd_en, .rdata, .callprog_tx_level, .callprog_rx_level,
    .callprog_tx_mute, .callprog_rx_mute, .line_side_powerdown, .system_side_powerdown,
    .sample_rate_select, .sample_rate_invalid);
`default_nettype wire

// ---- testbench/lictl_line_model.sv ----
/* Line-side chip model: link fault, frame lock and sense value.
   Assumes the bench commands faults and sense values. */
`timescale 1ns/1ps
`default_nettype none
module lictl_line_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       powerdown,
    input  wire logic       fault,
    input  wire logic [4:0] sense,
    output var  logic       link_error_pin,
    output var  logic       frame_lock_pin,
    output var  logic [4:0] line_sense_pin
);
    // Pins change after the edge; no lock while powered down
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            link_error_pin <= 1'b0;
            frame_lock_pin <= 1'b0;
            line_sense_pin <= 5'h00;
        end else begin
            link_error_pin <= fault;
            frame_lock_pin <= !powerdown;
            line_sense_pin <= sense;
        end
    end
endmodule // lictl_line_model
`default_nettype wire

// ---- testbench/tb_lictl_regs.sv ----
/* Self-checking bench of the register bank.
   Assumes the line model drives the status pins. */
`timescale 1ns/1ps
`default_nettype none
module tb_lictl_regs;
    localparam [3:0] REV = 4'h5; // Arbitrary revision
    logic clk = 0, resetn = 0, wr_en = 0, rd_en = 0, fault = 0, irq;
    logic [3:0] addr = 0;
    logic [7:0] wdata = 0, rdata, d;
    logic [4:0] sense = 0, line_sense_pin;
    logic link_error_pin, frame_lock_pin, callprog_tx_mute, callprog_rx_mute;
    logic line_side_powerdown, system_side_powerdown, sample_rate_invalid, off_hook_request;
    logic [1:0] callprog_tx_level, callprog_rx_level;
    logic [2:0] sample_rate_select;
    logic [4:0] sv [6] = '{5'h1e, 5'h01, 5'h15, 5'h1e, 5'h01, 5'h15};
    logic [3:0] lc [6] = '{4'he, 4'h1, 4'ha, 4'hf, 4'h0, 4'ha};
    logic [3:0] rs [5] = '{4'h0, 4'h2, 4'h7, 4'h8, 4'ha};
    int n_fail = 0, compares = 0, i;
    lictl_regs #(.REV_VALUE(REV)) i_lictl_regs (.clk, .resetn, .addr, .wdata, .wr_en,
        .rd_en, .rdata, .link_error_pin, .frame_lock_pin, .line_sense_pin,
        .callprog_tx_level, .callprog_rx_level, .callprog_tx_mute, .callprog_rx_mute,
        .line_side_powerdown, .system_side_powerdown, .sample_rate_select,
        .sample_rate_invalid, .off_hook_request, .irq);
    lictl_line_model i_lictl_line_model (.clk, .resetn, .powerdown(line_side_powerdown),
        .fault, .sense, .link_error_pin, .frame_lock_pin, .line_sense_pin);
    // Clock and hang guard
    initial forever #10 clk = ~clk;
    initial begin
        #400000;
        n_fail++;
        report_and_stop();
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr_en <= 1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr_en <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_en <= 1;
        addr <= a;
        @(posedge clk);
        rd_en <= 0;
        #1 chk(rdata, e);
    endtask
    task automatic report_and_stop();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1;
        rd(4'h6, 8'h70);
        rd(4'h9, 8'h00);
        wr(4'hb, 8'hff);
        rd(4'hb, {4'h0, REV});
        foreach (rs[k]) begin
            wr(rs[k], 8'hff);
            rd(rs[k], 8'h00);
        end
        rd(4'hd, 8'h00);
        chk({7'h0, line_side_powerdown}, 8'h01);
        $display("test reset done");
        for (i = 0; i < 16; i++) begin
            d = {1'b1, i[3], i[1], 3'b101, i[2], i[0]};
            wr(4'h6, d);
            rd(4'h6, d & 8'h7b);
            chk({callprog_tx_level, callprog_rx_level, 2'b0, callprog_tx_mute,
                callprog_rx_mute}, {i[3:0], 2'b0, i[3:2] == 2'b10, i[1:0] == 2'b10});
        end
        $display("test levels done");
        for (i = 0; i < 8; i++) begin
            wr(4'h9, {5'h1f, i[2:0]});
            rd(4'h9, {5'h0, i[2:0]});
            chk({sample_rate_invalid, sample_rate_select}, {i[2:0] == 3'h7, i[2:0]});
        end
        $display("test sample rate done");
        wr(4'he, 8'h07);
        wr(4'h6, 8'h00);
        for (i = 0; i < 6; i++) begin
            wr(4'h5, {7'h0, i < 3});
            sense <= sv[i];
            step(6);
            chk({7'h0, off_hook_request}, {7'h0, i < 3});
            rd(4'hc, {4'h4, lc[i]});
        end
        chk({7'h0, irq}, 8'h01);
        rd(4'hd, 8'h04);
        wr(4'hf, 8'h07);
        rd(4'hd, 8'h00);
        chk({7'h0, irq}, 8'h00);
        $display("test status done");
        fault <= 1;
        step(6);
        fault <= 0;
        step(6);
        wr(4'hc, 8'hff);
        rd(4'hc, 8'hca);
        chk({7'h0, irq}, 8'h01);
        wr(4'he, 8'h00);
        rd(4'he, 8'h00);
        chk({7'h0, irq}, 8'h00);
        wr(4'hc, 8'h00);
        rd(4'hc, 8'h4a);
        wr(4'h6, 8'h10);
        step(6);
        rd(4'hc, 8'h0a);
        chk({7'h0, line_side_powerdown}, 8'h01);
        $display("test link done");
        wr(4'h6, 8'h08);
        wr(4'h6, 8'h00);
        rd(4'h6, 8'h08);
        chk({7'h0, system_side_powerdown}, 8'h01);
        @(posedge clk);
        resetn <= 0;
        step(3);
        resetn <= 1;
        step(2);
        chk({7'h0, system_side_powerdown}, 8'h00);
        rd(4'h6, 8'h70);
        $display("test powerdown done");
        report_and_stop();
    end
endmodule // tb_lictl_regs
`default_nettype wire
